// *** pkg/pin_out_pkg.sv ***
/*
 * constants for the pin output select block: register offsets,
 * field positions, reset values and source/select codes.
 * assumes an apb slave with 32-bit data, one register per word.
 */
package pin_out_pkg;
    // printed offsets are not all multiples of four: indices, byte = 4*idx
    localparam logic [7:0] pin_a_ctl_index = 8'h11;
    localparam logic [7:0] pin_b_ctl_index = 8'h12;
    localparam logic [11:0] pin_a_ctl_addr = {2'h0, pin_a_ctl_index, 2'h0};
    localparam logic [11:0] pin_b_ctl_addr = {2'h0, pin_b_ctl_index, 2'h0};
    localparam logic [7:0] pin_b_ctl_reset = 8'h00;
    localparam logic [1:0] pin_a_ctl_reset = 2'h0;
    localparam int drive_enable_bit = 0;
    localparam int fixed_value_bit = 1;
    localparam int source_lsb = 2;
    localparam int select_lsb = 5;
    localparam logic [2:0] src_device_status = 3'h4;
    localparam logic [2:0] src_reserved = 3'h5;
    localparam int rx_ports = 4;
    localparam int tx_ports = 2;
endpackage : pin_out_pkg

// *** design/pin_signal_mux.sv ***
/*
 * pin_signal_mux: picks one pin's output level from source and select.
 * assumes status inputs are synchronous to pclk.
 */
`timescale 1ns/10ps
module pin_signal_mux
(
    input wire logic [2:0] source_select,
    input wire logic [2:0] signal_select,
    input wire logic fixed_value,
    input wire logic [pin_out_pkg::rx_ports-1:0] rx_enabled,
    input wire logic [pin_out_pkg::rx_ports-1:0] rx_lock,
    input wire logic [pin_out_pkg::rx_ports-1:0] rx_pass,
    input wire logic [pin_out_pkg::rx_ports-1:0] rx_line_valid,
    input wire logic [4*pin_out_pkg::rx_ports-1:0] rx_remote_pins,
    input wire logic [pin_out_pkg::rx_ports-1:0] tx0_port_select,
    input wire logic [pin_out_pkg::rx_ports-1:0] tx1_port_select,
    output logic level
);
    import pin_out_pkg::*;

    logic [rx_ports-1:0] tx_sel;
    logic [1:0] port;
    always_comb
    begin
        level = 1'b0;
        port = source_select[1:0];
        tx_sel = source_select[0] ? tx1_port_select : tx0_port_select;
        if (!source_select[2])
        begin
            case (signal_select)
                3'h0: level = rx_remote_pins[4*port];
                3'h1: level = rx_remote_pins[4*port+2];
                3'h3: level = rx_remote_pins[4*port+3];
                3'h4: level = rx_lock[port];
                3'h5: level = rx_pass[port];
                3'h7: level = rx_line_valid[port];
                default: level = 1'b0;
            endcase
        end
        else if (source_select == src_device_status)
        begin
            case (signal_select)
                3'h0: level = fixed_value;
                3'h1: level = |(rx_lock & rx_enabled);
                3'h2: level = &(rx_lock | ~rx_enabled);
                3'h3: level = &(rx_pass | ~rx_enabled);
                default: level = 1'b0;
            endcase
        end
        else if (source_select != src_reserved)
        begin
            // empty port selection: and reads low rather than vacuously high
            case (signal_select)
                3'h0: level = |tx_sel & &(rx_pass | ~tx_sel);
                3'h1: level = |(rx_pass & tx_sel);
                default: level = 1'b0;
            endcase
        end
    end
endmodule : pin_signal_mux

// *** design/pin_output_select.sv ***
/*
 * pin_output_select: apb slave holding the pin a value/enable bits and the
 * full pin b control register, driving both pins through output enables.
 * assumes receive/transmit status inputs synchronous to pclk.
 */
// Implementation choice: register access over APB.
//
// Functional notes
// - bits 4:2 choose pin output source
// - receive source selects forwarded remote pin
// - receive source selects lock, pass, line valid
// - transmit source selects pass and or or
// - status source: value, lock or/and, pass and
// - bit 1 holds fixed level, readable
// - bit 0 enables the pin driver
// - pin b register 0x12 resets 0x00
`timescale 1ns/10ps
module pin_output_select
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pin_out_pkg::rx_ports-1:0] rx_enabled,
    input wire logic [pin_out_pkg::rx_ports-1:0] rx_lock,
    input wire logic [pin_out_pkg::rx_ports-1:0] rx_pass,
    input wire logic [pin_out_pkg::rx_ports-1:0] rx_line_valid,
    input wire logic [4*pin_out_pkg::rx_ports-1:0] rx_remote_pins,
    input wire logic [pin_out_pkg::rx_ports-1:0] tx0_port_select,
    input wire logic [pin_out_pkg::rx_ports-1:0] tx1_port_select,
    input wire logic pin_a_in,
    input wire logic pin_b_in,
    output logic pin_a_out,
    output logic pin_a_oe_n,
    output logic pin_b_out,
    output logic pin_b_oe_n
);
    import pin_out_pkg::*;

    typedef struct packed {
        logic [7:0] pin_b_output_control;
        logic [1:0] pin_a_output_control;
        logic [31:0] rdata;
        logic b_level;
        logic b_oe_n;
        logic a_level;
        logic a_oe_n;
    } state_t;

    state_t cur;
    state_t next_cur;
    logic b_selected;
    logic wr;
    logic rd;
    logic hit_a;
    logic hit_b;

    pin_signal_mux u_mux (
        .source_select(cur.pin_b_output_control[source_lsb +: 3]),
        .signal_select(cur.pin_b_output_control[select_lsb +: 3]),
        .fixed_value(cur.pin_b_output_control[fixed_value_bit]),
        .rx_enabled(rx_enabled),
        .rx_lock(rx_lock),
        .rx_pass(rx_pass),
        .rx_line_valid(rx_line_valid),
        .rx_remote_pins(rx_remote_pins),
        .tx0_port_select(tx0_port_select),
        .tx1_port_select(tx1_port_select),
        .level(b_selected)
    );

    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign hit_a = (paddr == pin_a_ctl_addr);
    assign hit_b = (paddr == pin_b_ctl_addr);
    assign pslverr = psel & penable & ~(hit_a | hit_b);
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;

    always_comb
    begin
        next_cur = cur;
        if (wr && hit_b)
            next_cur.pin_b_output_control = pwdata[7:0];
        if (wr && hit_a)
            next_cur.pin_a_output_control = pwdata[1:0];
        // read data captured in setup, so it is stable for the access phase
        if (rd)
        begin
            if (hit_b)
                next_cur.rdata = {24'h0, cur.pin_b_output_control};
            else if (hit_a)
                next_cur.rdata = {30'h0, cur.pin_a_output_control};
            else
                next_cur.rdata = 32'h0;
        end
        // a disabled pin holds its output low as well as undriven
        next_cur.b_oe_n = ~cur.pin_b_output_control[drive_enable_bit];
        next_cur.b_level = cur.pin_b_output_control[drive_enable_bit]
            & b_selected;
        next_cur.a_oe_n = ~cur.pin_a_output_control[drive_enable_bit];
        next_cur.a_level = cur.pin_a_output_control[drive_enable_bit]
            & cur.pin_a_output_control[fixed_value_bit];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur <= '0;
            cur.pin_b_output_control <= pin_b_ctl_reset;
            cur.pin_a_output_control <= pin_a_ctl_reset;
            cur.b_oe_n <= 1'b1;
            cur.a_oe_n <= 1'b1;
        end
        else
            cur <= next_cur;
    end

    assign prdata = cur.rdata;
    assign pin_a_out = cur.a_level;
    assign pin_a_oe_n = cur.a_oe_n;
    assign pin_b_out = cur.b_level;
    assign pin_b_oe_n = cur.b_oe_n;

    // pin inputs are only looked at by external readback, unused here
    logic unused_in;
    assign unused_in = pin_a_in ^ pin_b_in;

    AST_B_WRITE: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && hit_b |=> cur.pin_b_output_control == $past(pwdata[7:0]))
        else $error("pin b register write lost");
    AST_B_OE: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && hit_b |-> ##2 pin_b_oe_n == !$past(pwdata[0], 2))
        else $error("pin b enable wrong");
    AST_A_OE: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr && hit_a |-> ##2 pin_a_oe_n == !$past(pwdata[0], 2))
        else $error("pin a enable wrong");
    AST_B_QUIET: assert property (
        @(posedge pclk) disable iff (!presetn)
        pin_b_oe_n |-> !pin_b_out)
        else $error("disabled pin b driven");
    AST_A_QUIET: assert property (
        @(posedge pclk) disable iff (!presetn)
        pin_a_oe_n |-> !pin_a_out)
        else $error("disabled pin a driven");
    AST_A_VAL: assert property (
        @(posedge pclk) disable iff (!presetn)
        !pin_a_oe_n && $stable(cur.pin_a_output_control)
        |-> pin_a_out == cur.pin_a_output_control[1])
        else $error("pin a value wrong");
    AST_READ_B: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd && hit_b |=> prdata[7:0] == $past(cur.pin_b_output_control))
        else $error("pin b readback wrong");
    AST_B_SEL: assert property (
        @(posedge pclk) disable iff (!presetn)
        cur.pin_b_output_control[0] |=> pin_b_out == $past(b_selected))
        else $error("pin b level not from source");
    // the reserved source must not leak any status onto the pin
    AST_B_RESERVED: assert property (
        @(posedge pclk) disable iff (!presetn)
        cur.pin_b_output_control[4:2] == src_reserved |-> !b_selected)
        else $error("reserved source drives pin b");
    AST_B_STATUS: assert property (
        @(posedge pclk) disable iff (!presetn)
        cur.pin_b_output_control[4:2] == src_device_status
        && cur.pin_b_output_control[7:5] == 3'h0
        |-> b_selected == cur.pin_b_output_control[1])
        else $error("status value select wrong");
    AST_STATUS_OR: assert property (
        @(posedge pclk) disable iff (!presetn)
        cur.pin_b_output_control[4:2] == src_device_status
        && cur.pin_b_output_control[7:5] == 3'h1
        |-> b_selected == ((rx_lock & rx_enabled) != '0))
        else $error("status lock or wrong");
    AST_STATUS_AND: assert property (
        @(posedge pclk) disable iff (!presetn)
        cur.pin_b_output_control[4:2] == src_device_status
        && cur.pin_b_output_control[7:5] == 3'h2
        |-> b_selected == ((rx_lock & rx_enabled) == rx_enabled))
        else $error("status lock and wrong");
    AST_STATUS_PASS: assert property (
        @(posedge pclk) disable iff (!presetn)
        cur.pin_b_output_control[4:2] == src_device_status
        && cur.pin_b_output_control[7:5] == 3'h3
        |-> b_selected == ((rx_pass & rx_enabled) == rx_enabled))
        else $error("status pass and wrong");
    AST_RX_LOCK: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cur.pin_b_output_control[4]
        && cur.pin_b_output_control[7:5] == 3'h4
        |-> b_selected == rx_lock[cur.pin_b_output_control[3:2]])
        else $error("receive lock select wrong");
    AST_RX_PASS: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cur.pin_b_output_control[4]
        && cur.pin_b_output_control[7:5] == 3'h5
        |-> b_selected == rx_pass[cur.pin_b_output_control[3:2]])
        else $error("receive pass select wrong");
    AST_RX_LV: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cur.pin_b_output_control[4]
        && cur.pin_b_output_control[7:5] == 3'h7
        |-> b_selected == rx_line_valid[cur.pin_b_output_control[3:2]])
        else $error("receive line valid select wrong");
    AST_RX_PIN: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cur.pin_b_output_control[4]
        && cur.pin_b_output_control[7:5] == 3'h0
        |-> b_selected == rx_remote_pins[4*cur.pin_b_output_control[3:2]])
        else $error("remote pin select wrong");
    AST_RX_PIN2: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cur.pin_b_output_control[4]
        && cur.pin_b_output_control[7:5] == 3'h1
        |-> b_selected == rx_remote_pins[4*cur.pin_b_output_control[3:2]+2])
        else $error("remote pin 2 select wrong");
    AST_TX_AND: assert property (
        @(posedge pclk) disable iff (!presetn)
        cur.pin_b_output_control[4:2] == 3'h6
        && cur.pin_b_output_control[7:5] == 3'h0
        |-> b_selected == (tx0_port_select != '0
        && (rx_pass & tx0_port_select) == tx0_port_select))
        else $error("transmit pass and wrong");
    AST_TX_OR: assert property (
        @(posedge pclk) disable iff (!presetn)
        cur.pin_b_output_control[4:2] == 3'h6
        && cur.pin_b_output_control[7:5] == 3'h1
        |-> b_selected == |(rx_pass & tx0_port_select))
        else $error("transmit pass or wrong");
    AST_TX1_OR: assert property (
        @(posedge pclk) disable iff (!presetn)
        cur.pin_b_output_control[4:2] == 3'h7
        && cur.pin_b_output_control[7:5] == 3'h1
        |-> b_selected == |(rx_pass & tx1_port_select))
        else $error("transmit 1 pass or wrong");

    COV_B_WRITE: cover property (@(posedge pclk) wr && hit_b);
    COV_B_DRIVE: cover property (@(posedge pclk) !pin_b_oe_n && pin_b_out);
    COV_A_DRIVE: cover property (@(posedge pclk) !pin_a_oe_n && pin_a_out);
    COV_ERR: cover property (@(posedge pclk) pslverr);
    COV_TX_SRC: cover property (@(posedge pclk)
        cur.pin_b_output_control[4:3] == 2'b11 && !pin_b_oe_n);
endmodule : pin_output_select

// *** verif/pin_load.sv ***
/*
 * pin_load: board pull-ups on the two general-purpose pins.
 * assumes active-low output enables from the block.
 */
`timescale 1ns/10ps
module pin_load
(
    input wire logic a_out,
    input wire logic a_oe_n,
    input wire logic b_out,
    input wire logic b_oe_n,
    output logic a_level,
    output logic b_level
);
    // a released pin floats up, so a stale driven low cannot pass for idle
    assign a_level = a_oe_n ? 1'b1 : a_out;
    assign b_level = b_oe_n ? 1'b1 : b_out;
endmodule : pin_load

// *** verif/gpio_pin_output_select_test.sv ***
/*
 * gpio_pin_output_select_test: apb sequences checking pin source selects.
 * assumes pin_output_select, pin_out_pkg and pin_load are compiled first.
 */
`timescale 1ns/10ps
module gpio_pin_output_select_test;
    import pin_out_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] q;
    logic pready, pslverr, last_err;
    logic [3:0] en = 4'h7, lock = 4'h5, pass = 4'h3, lv = 4'h9;
    logic [3:0] s0 = 4'h3, s1 = 4'h6;
    logic [15:0] rp = 16'h5a3c;
    logic a_out, a_oe_n, b_out, b_oe_n, a_lvl, b_lvl, e;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int codes [6] = '{0, 1, 3, 4, 5, 7};
    always #12.5 pclk = ~pclk;
    pin_output_select u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_enabled(en), .rx_lock(lock), .rx_pass(pass),
        .rx_line_valid(lv), .rx_remote_pins(rp), .tx0_port_select(s0),
        .tx1_port_select(s1), .pin_a_in(a_lvl), .pin_b_in(b_lvl),
        .pin_a_out(a_out), .pin_a_oe_n(a_oe_n), .pin_b_out(b_out),
        .pin_b_oe_n(b_oe_n));
    pin_load u_load (.a_out(a_out), .a_oe_n(a_oe_n), .b_out(b_out),
        .b_oe_n(b_oe_n), .a_level(a_lvl), .b_level(b_lvl));
    task test_done;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    // holds the request until pready is seen high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait-state count assumed; only the cycle ceiling ends a hang
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // pins are registered one edge after the control register
    task pin_b(input logic [7:0] c, input logic x_out, input logic x_oe_n);
        apb(1'b1, pin_b_ctl_addr, {24'h0, c});
        repeat (2) @(posedge pclk);
        #1;
        chk("pin_b_out", {31'h0, x_out}, {31'h0, b_out});
        chk("pin_b_oe_n", {31'h0, x_oe_n}, {31'h0, b_oe_n});
    endtask : pin_b
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            test_done();
        end
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("pin_b_oe_n", 32'h1, {31'h0, b_oe_n});
        apb(1'b0, pin_b_ctl_addr, 32'h0);
        chk("pin_b_ctl", 32'h0, q);
        apb(1'b0, 12'h000, 32'h0);
        chk("unmapped", 32'h0, q);
        chk("pslverr", 32'h1, {31'h0, last_err});
        $display("test reset done");
        apb(1'b1, pin_a_ctl_addr, 32'h3);
        apb(1'b0, pin_a_ctl_addr, 32'h0);
        chk("pin_a_ctl", 32'h3, q);
        chk("pin_a_out", 32'h0, {30'h0, a_oe_n, a_out} ^ 32'h1);
        apb(1'b1, pin_a_ctl_addr, 32'h2);
        repeat (2) @(posedge pclk);
        #1;
        chk("pin_a_oe_n", 32'h1, {31'h0, a_oe_n});
        chk("pin_a_out", 32'h0, {31'h0, a_out});
        chk("pin_a_level", 32'h1, {31'h0, a_lvl});
        pin_b(8'h13, 1'b1, 1'b0);
        apb(1'b0, pin_b_ctl_addr, 32'h0);
        chk("pin_b_ctl", 32'h13, q);
        pin_b(8'h12, 1'b0, 1'b1);
        chk("pin_b_level", 32'h1, {31'h0, b_lvl});
        $display("test fixed value done");
        pin_b(8'h31, 1'b1, 1'b0);
        pin_b(8'h51, 1'b0, 1'b0);
        pin_b(8'h71, 1'b0, 1'b0);
        pin_b(8'h17, 1'b0, 1'b0);
        pin_b(8'h19, 1'b1, 1'b0);
        pin_b(8'h39, 1'b1, 1'b0);
        pin_b(8'h1d, 1'b0, 1'b0);
        pin_b(8'h3d, 1'b1, 1'b0);
        $display("test status and transmit done");
        for (int p = 0; p < 4; p++)
        begin
            for (int k = 0; k < 6; k++)
            begin
                case (codes[k])
                    0: e = rp[4*p];
                    1: e = rp[4*p+2];
                    3: e = rp[4*p+3];
                    4: e = lock[p];
                    5: e = pass[p];
                    default: e = lv[p];
                endcase
                pin_b({codes[k][2:0], p[2:0], 2'b01}, e, 1'b0);
            end
        end
        $display("test receive sources done");
        pin_b(8'h45, 1'b0, 1'b0);
        pin_b(8'hc5, 1'b0, 1'b0);
        pin_b(8'h93, 1'b0, 1'b0);
        pin_b(8'h59, 1'b0, 1'b0);
        @(posedge pclk);
        en <= 4'h5;
        s0 <= 4'h0;
        pin_b(8'h51, 1'b1, 1'b0);
        pin_b(8'h19, 1'b0, 1'b0);
        pin_b(8'hff, 1'b0, 1'b0);
        $display("test reserved codes and masks done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("pin_b_oe_n", 32'h1, {31'h0, b_oe_n});
        apb(1'b0, pin_b_ctl_addr, 32'h0);
        chk("pin_b_ctl", 32'h0, q);
        apb(1'b0, pin_a_ctl_addr, 32'h0);
        chk("pin_a_ctl", 32'h0, q);
        $display("test second reset done");
        test_done();
    end
endmodule : gpio_pin_output_select_test
